// [rtl/step_up_strobe_regs.sv]
/*
 * Serial bus slave with the step-up converter control register and the
 * two strobe flash current registers, plus decoded settings for the
 * analog side. Assumes an open-drain data line resolved outside and a
 * bus clock far slower than i_clk (at least 10 clocks per bus phase).
 */
`timescale 1ns/10ps
`default_nettype none
module step_up_strobe_regs (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Serial bus pins
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe,
   // Converter settings
   output logic             o_converter_on,
   output logic [1:0]       o_regulation_select,
   output logic             o_adaptive_mode,
   output logic             o_fixed_target,
   output logic             o_dropout_mode,
   output logic             o_auto_mode,
   output logic [12:0]      o_target_mv,
   // Strobe currents, units of 10 uA
   output logic [16:0]      o_strobe_one_current,
   output logic [16:0]      o_strobe_two_current
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
      ST_WRITE, ST_ACK_WRITE, ST_READ, ST_ACK_READ
   } bus_state_type;

   bus_state_type state_q, state_d;
   logic [7:0]    shift_q, shift_d;
   logic [3:0]    bitcnt_q, bitcnt_d;
   logic [7:0]    ptr_q, ptr_d;
   logic          rw_q, rw_d;
   logic          oe_q, oe_d;
   logic [7:0]    ctrl_q, ctrl_d;
   logic [7:0]    cur1_q, cur1_d;
   logic [7:0]    cur2_q, cur2_d;
   logic [1:0]    sel_q, sel_d;
   logic          on_q, on_d;
   logic [12:0]   mv_q, mv_d;
   logic [16:0]   ma1_q, ma1_d;
   logic [16:0]   ma2_q, ma2_d;
   logic          scl_lvl, scl_rise, scl_fall;
   logic          sda_lvl, sda_rise, sda_fall;
   logic          start_cond, stop_cond, wr_now;
   logic [7:0]    rd_value;

   pin_filter u_scl (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_pin   (i_scl),
      .o_level (scl_lvl),
      .o_rise  (scl_rise),
      .o_fall  (scl_fall)
   );

   pin_filter u_sda (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_pin   (i_sda),
      .o_level (sda_lvl),
      .o_rise  (sda_rise),
      .o_fall  (sda_fall)
   );

   // Strobe current lookup: linear steps, top two codes as listed
   function automatic logic [16:0] strobe_current(input logic [4:0] code);
      logic [16:0] val;
      val = 17'(code) * strobe_regs_pkg::CUR_STEP
            + strobe_regs_pkg::CUR_STEP;
      if (code == strobe_regs_pkg::CUR_CODE_30) begin
         val = strobe_regs_pkg::CUR_VAL_30;
      end else if (code == strobe_regs_pkg::CUR_CODE_31) begin
         val = strobe_regs_pkg::CUR_VAL_31;
      end
      return val;
   endfunction : strobe_current

   assign start_cond = scl_lvl & sda_fall;
   assign stop_cond  = scl_lvl & sda_rise;
   assign wr_now     = (state_q == ST_WRITE) && scl_fall
                       && (bitcnt_q == strobe_regs_pkg::BYTE_BITS);

   // Read-back of implemented fields; unmapped pointers read zero
   always_comb begin
      unique case (ptr_q)
         strobe_regs_pkg::PTR_STEP_UP:    rd_value = ctrl_q;
         strobe_regs_pkg::PTR_STROBE_ONE: rd_value = cur1_q;
         strobe_regs_pkg::PTR_STROBE_TWO: rd_value = cur2_q;
         default:                rd_value = strobe_regs_pkg::READ_UNMAPPED;
      endcase
   end

   // Bus protocol state machine
   always_comb begin
      state_d  = state_q;
      shift_d  = shift_q;
      bitcnt_d = bitcnt_q;
      ptr_d    = ptr_q;
      rw_d     = rw_q;
      oe_d     = oe_q;
      if (stop_cond) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (start_cond) begin
         state_d  = ST_ADDR;
         bitcnt_d = 4'h0;
         oe_d     = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: ;
            ST_ADDR, ST_PTR, ST_WRITE: begin
               if (scl_rise) begin
                  shift_d  = {shift_q[6:0], sda_lvl};
                  bitcnt_d = bitcnt_q + 4'h1;
               end else if (scl_fall
                            && bitcnt_q == strobe_regs_pkg::BYTE_BITS) begin
                  oe_d = 1'b1;
                  if (state_q == ST_ADDR) begin
                     rw_d = shift_q[0];
                     if (shift_q[7:1] == strobe_regs_pkg::BUS_ADDR) begin
                        state_d = ST_ACK_ADDR;
                     end else begin
                        state_d = ST_IDLE;
                        oe_d    = 1'b0;
                     end
                  end else if (state_q == ST_PTR) begin
                     ptr_d   = shift_q;
                     state_d = ST_ACK_PTR;
                  end else begin
                     ptr_d   = ptr_q + 8'h01;
                     state_d = ST_ACK_WRITE;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  bitcnt_d = 4'h0;
                  if (rw_q) begin
                     shift_d = rd_value;
                     oe_d    = ~rd_value[7];
                     state_d = ST_READ;
                  end else begin
                     oe_d    = 1'b0;
                     state_d = ST_PTR;
                  end
               end
            end
            ST_ACK_PTR, ST_ACK_WRITE: begin
               if (scl_fall) begin
                  oe_d     = 1'b0;
                  bitcnt_d = 4'h0;
                  state_d  = ST_WRITE;
               end
            end
            ST_READ: begin
               if (scl_rise) begin
                  bitcnt_d = bitcnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt_q == strobe_regs_pkg::BYTE_BITS) begin
                     oe_d    = 1'b0;
                     ptr_d   = ptr_q + 8'h01;
                     state_d = ST_ACK_READ;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d    = ~shift_q[6];
                  end
               end
            end
            ST_ACK_READ: begin
               if (scl_rise && sda_lvl) begin
                  state_d = ST_IDLE;
               end else if (scl_fall) begin
                  bitcnt_d = 4'h0;
                  shift_d  = rd_value;
                  oe_d     = ~rd_value[7];
                  state_d  = ST_READ;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state_q  <= ST_IDLE;
         shift_q  <= 8'h00;
         bitcnt_q <= 4'h0;
         ptr_q    <= 8'h00;
         rw_q     <= 1'b0;
         oe_q     <= 1'b0;
      end else begin
         state_q  <= state_d;
         shift_q  <= shift_d;
         bitcnt_q <= bitcnt_d;
         ptr_q    <= ptr_d;
         rw_q     <= rw_d;
         oe_q     <= oe_d;
      end
   end

   // Register bank; reserved bits are never stored
   always_comb begin
      ctrl_d = ctrl_q;
      cur1_d = cur1_q;
      cur2_d = cur2_q;
      if (wr_now) begin
         unique case (ptr_q)
            strobe_regs_pkg::PTR_STEP_UP:
               ctrl_d = shift_q & strobe_regs_pkg::MASK_STEP_UP;
            strobe_regs_pkg::PTR_STROBE_ONE:
               cur1_d = shift_q & strobe_regs_pkg::MASK_STROBE;
            strobe_regs_pkg::PTR_STROBE_TWO:
               cur2_d = shift_q & strobe_regs_pkg::MASK_STROBE;
            default: ;
         endcase
      end
      on_d  = ctrl_d[strobe_regs_pkg::CONV_ON_POS];
      sel_d = ctrl_d[strobe_regs_pkg::SEL_HI:strobe_regs_pkg::SEL_LO];
      mv_d  = strobe_regs_pkg::VOUT_BASE_MV + 13'(ctrl_d[
              strobe_regs_pkg::VCODE_HI:strobe_regs_pkg::VCODE_LO])
              * strobe_regs_pkg::VOUT_STEP_MV;
      ma1_d = strobe_current(
              cur1_d[strobe_regs_pkg::CUR_HI:strobe_regs_pkg::CUR_LO]);
      ma2_d = strobe_current(
              cur2_d[strobe_regs_pkg::CUR_HI:strobe_regs_pkg::CUR_LO]);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ctrl_q <= strobe_regs_pkg::RST_STEP_UP;
         cur1_q <= strobe_regs_pkg::RST_STROBE;
         cur2_q <= strobe_regs_pkg::RST_STROBE;
         on_q   <= 1'b0;
         sel_q  <= strobe_regs_pkg::SEL_ADAPTIVE;
         mv_q   <= strobe_regs_pkg::VOUT_BASE_MV;
         ma1_q  <= strobe_regs_pkg::CUR_STEP;
         ma2_q  <= strobe_regs_pkg::CUR_STEP;
      end else begin
         ctrl_q <= ctrl_d;
         cur1_q <= cur1_d;
         cur2_q <= cur2_d;
         on_q   <= on_d;
         sel_q  <= sel_d;
         mv_q   <= mv_d;
         ma1_q  <= ma1_d;
         ma2_q  <= ma2_d;
      end
   end

   assign o_sda                = 1'b0;
   assign o_sda_oe             = oe_q;
   assign o_converter_on       = on_q;
   assign o_regulation_select  = sel_q;
   assign o_adaptive_mode  = (sel_q == strobe_regs_pkg::SEL_ADAPTIVE);
   assign o_dropout_mode   = (sel_q == strobe_regs_pkg::SEL_DROPOUT);
   assign o_fixed_target   = (sel_q == strobe_regs_pkg::SEL_FIXED);
   assign o_auto_mode      = (sel_q == strobe_regs_pkg::SEL_AUTO);
   assign o_target_mv          = mv_q;
   assign o_strobe_one_current = ma1_q;
   assign o_strobe_two_current = ma2_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_byte_written;
      wr_now && ptr_q == strobe_regs_pkg::PTR_STEP_UP;
   endsequence

   a_ctrl_reset: assert property ($rose(i_nrst) |-> ctrl_q == 8'h00)
      else $error("control register not zero after reset");
   a_conv_on_write: assert property (s_byte_written |=>
      o_converter_on == $past(shift_q[6]))
      else $error("converter enable does not follow write");
   a_mode_dropout: assert property (ctrl_q[5:4] == 2'h2 |->
      o_dropout_mode && !o_adaptive_mode && !o_auto_mode)
      else $error("dropout select not decoded");
   a_fixed_target: assert property (o_fixed_target |->
      o_target_mv == 13'h0E74 + 13'(ctrl_q[3:0]) * 13'h0064)
      else $error("fixed target voltage wrong");
   a_auto_mode: assert property (o_auto_mode == (ctrl_q[5:4] == 2'h3))
      else $error("automatic mode not decoded");
   a_voltage_range: assert property (o_target_mv >= 13'h0E74
      && o_target_mv <= 13'h1450)
      else $error("target voltage outside 3.7 V to 5.2 V");
   a_strobe_one_min: assert property (cur1_q[7:3] == 5'h00 |->
      o_strobe_one_current == 17'h0_0928)
      else $error("strobe one lowest current wrong");
   a_strobe_two_hi: assert property (cur2_q[7:3] == 5'h1E |->
      o_strobe_two_current == 17'h1_1BD0)
      else $error("strobe two code 30 current wrong");
   a_strobe_regs_rst: assert property ($rose(i_nrst) |->
      cur1_q == 8'h00 && cur2_q == 8'h00)
      else $error("strobe registers not zero after reset");
   a_reserved_zero: assert property (!ctrl_q[7] && cur1_q[2:0] == 3'h0
      && cur2_q[2:0] == 3'h0)
      else $error("reserved bit set");
   a_ptr_advance: assert property (wr_now |=> ptr_q == $past(ptr_q) + 8'h01
      )
      else $error("pointer did not advance after data byte");
   a_ptr_ack: assert property (state_q == ST_ACK_PTR |-> o_sda_oe)
      else $error("pointer byte not acknowledged");
   a_read_back: assert property (state_q == ST_ACK_ADDR && rw_q && scl_fall
      && !stop_cond && !start_cond |=> shift_q == $past(rd_value))
      else $error("read data not loaded from register");
endmodule : step_up_strobe_regs
`default_nettype wire

// [rtl/strobe_regs_pkg.sv]
/*
 * Constants of the step-up converter and strobe current register bank:
 * serial bus address, register pointers, field positions, reset values
 * and the scaling of the decoded converter and strobe settings.
 * Assumes nothing of its surroundings.
 */
package strobe_regs_pkg;

   // Serial bus address; value is arbitrary
   localparam logic [6:0]  BUS_ADDR          = 7'h4A;

   // Register pointers
   localparam logic [7:0]  PTR_STEP_UP       = 8'h00;
   localparam logic [7:0]  PTR_STROBE_ONE    = 8'h01;
   localparam logic [7:0]  PTR_STROBE_TWO    = 8'h02;

   // Reset values and implemented-bit masks
   localparam logic [7:0]  RST_STEP_UP       = 8'h00;
   localparam logic [7:0]  RST_STROBE        = 8'h00;
   localparam logic [7:0]  MASK_STEP_UP      = 8'h7F;
   localparam logic [7:0]  MASK_STROBE       = 8'hF8;
   localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

   // Field positions
   localparam int          CONV_ON_POS       = 6;
   localparam int          SEL_HI            = 5;
   localparam int          SEL_LO            = 4;
   localparam int          VCODE_HI          = 3;
   localparam int          VCODE_LO          = 0;
   localparam int          CUR_HI            = 7;
   localparam int          CUR_LO            = 3;

   // Regulation select codes
   localparam logic [1:0]  SEL_ADAPTIVE      = 2'h0;
   localparam logic [1:0]  SEL_FIXED         = 2'h1;
   localparam logic [1:0]  SEL_DROPOUT       = 2'h2;
   localparam logic [1:0]  SEL_AUTO          = 2'h3;

   // Output voltage in mV: base plus code times step
   localparam logic [12:0] VOUT_BASE_MV      = 13'h0E74;
   localparam logic [12:0] VOUT_STEP_MV      = 13'h0064;

   // Strobe current in units of 10 uA
   localparam logic [16:0] CUR_STEP          = 17'h0_0928;
   localparam logic [4:0]  CUR_CODE_30       = 5'h1E;
   localparam logic [4:0]  CUR_CODE_31       = 5'h1F;
   localparam logic [16:0] CUR_VAL_30        = 17'h1_1BD0;
   localparam logic [16:0] CUR_VAL_31        = 17'h1_24F8;

   // Bits per byte on the serial bus
   localparam logic [3:0]  BYTE_BITS         = 4'h8;

endpackage : strobe_regs_pkg

// [rtl/pin_filter.sv]
/*
 * Three-stage input filter for one bus pin, with level and edge pulses.
 * Assumes the pin is asynchronous to i_clk and idles high.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_filter (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_nrst,
   // Pin
   input  wire logic i_pin,
   // Filtered view
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic       level_q;
   logic       level_d;

   // Level follows only once second and third stages agree
   always_comb begin
      stage_d = {stage_q[1:0], i_pin};
      level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         stage_q <= 3'h7;
         level_q <= 1'b1;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
      end
   end

   assign o_level = level_q;
   assign o_rise  = level_d & ~level_q;
   assign o_fall  = ~level_d & level_q;
endmodule : pin_filter
`default_nettype wire

// [tb/i2c_host_model.sv]
/*
 * Serial bus host model: START, repeated START, STOP and byte transfers.
 * Assumes the data wire is resolved outside with a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
   // Clock
   input  wire logic i_clk,
   // Bus
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_pull
);
   localparam int HALF = 20;

   initial begin
      o_scl      = 1'b1;
      o_sda_pull = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wait_clk

   // Also used as repeated START with SCL low
   task automatic start_cond();
      wait_clk(4);
      o_sda_pull = 1'b0;
      wait_clk(HALF);
      o_scl = 1'b1;
      wait_clk(HALF);
      o_sda_pull = 1'b1;
      wait_clk(HALF);
      o_scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      wait_clk(4);
      o_sda_pull = 1'b1;
      wait_clk(HALF);
      o_scl = 1'b1;
      wait_clk(HALF);
      o_sda_pull = 1'b0;
      wait_clk(HALF);
   endtask : stop_cond

   // SDA changes only a few clocks after SCL falls, never while high
   task automatic bit_out(input logic b);
      wait_clk(4);
      o_sda_pull = ~b;
      wait_clk(HALF);
      o_scl = 1'b1;
      wait_clk(HALF);
      o_scl = 1'b0;
   endtask : bit_out

   task automatic bit_in(output logic b);
      wait_clk(4);
      o_sda_pull = 1'b0;
      wait_clk(HALF);
      o_scl = 1'b1;
      wait_clk(HALF / 2);
      b = i_sda;
      wait_clk(HALF / 2);
      o_scl = 1'b0;
   endtask : bit_in

   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_out(d[i]);
      end
      bit_in(b);
      ack = ~b;
   endtask : write_byte

   task automatic read_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit_in(d[i]);
      end
      bit_out(last);
   endtask : read_byte

endmodule : i2c_host_model
`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench of the converter and strobe register bank.
 * Assumes the host model drives the bus and the wire has a pull-up.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        i_clk;
   logic        i_nrst;
   logic        scl;
   logic        pull;
   logic        sda;
   logic        o_sda;
   logic        o_sda_oe;
   logic        conv_on;
   logic [1:0]  sel;
   logic        m_ad;
   logic        m_fx;
   logic        m_dr;
   logic        m_au;
   logic [12:0] mv;
   logic [16:0] cur1;
   logic [16:0] cur2;
   logic [7:0]  wbuf [0:3];
   logic [7:0]  rbuf [0:3];
   logic [7:0]  exp_reg [0:2];
   int          err_count;
   int          comparisons;
   int          cycles;
   int          seed;

   // Open-drain wire: low when the host or the device pulls, else pulled up
   assign sda = (pull || (o_sda_oe && !o_sda)) ? 1'b0 : 1'b1;

   i2c_host_model host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
                        .o_sda_pull(pull));

   step_up_strobe_regs DUT (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
      .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_converter_on(conv_on),
      .o_regulation_select(sel), .o_adaptive_mode(m_ad),
      .o_fixed_target(m_fx), .o_dropout_mode(m_dr), .o_auto_mode(m_au),
      .o_target_mv(mv), .o_strobe_one_current(cur1),
      .o_strobe_two_current(cur2));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         $display("Error at %0t: timeout", $time);
         tally_and_finish();
      end
   end

   task automatic chk_val(input logic [16:0] got, input logic [16:0] e);
      comparisons++;
      if (got !== e) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, e);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic e);
      comparisons++;
      if (got !== e) begin
         err_count++;
         $display("Error at %0t: bit %b expected %b", $time, got, e);
      end
   endtask : chk_bit

   function automatic logic [16:0] exp_cur(input logic [4:0] c);
      if (c == 5'h1E) return strobe_regs_pkg::CUR_VAL_30;
      if (c == 5'h1F) return strobe_regs_pkg::CUR_VAL_31;
      return (17'(c) + 17'h0_0001) * strobe_regs_pkg::CUR_STEP;
   endfunction : exp_cur

   task automatic send_head(input logic [7:0] ptr);
      logic ack;
      host.start_cond();
      host.write_byte({strobe_regs_pkg::BUS_ADDR, 1'b0}, ack);
      chk_bit(ack, 1'b1);
      host.write_byte(ptr, ack);
      chk_bit(ack, 1'b1);
   endtask : send_head

   task automatic wr_regs(input logic [7:0] ptr, input int n);
      logic ack;
      send_head(ptr);
      for (int k = 0; k < n; k++) begin
         host.write_byte(wbuf[k], ack);
         chk_bit(ack, 1'b1);
         if (ptr + k < 3) exp_reg[ptr + k] = wbuf[k];
      end
      host.stop_cond();
   endtask : wr_regs

   task automatic rd_regs(input logic [7:0] ptr, input int n);
      logic ack;
      send_head(ptr);
      host.start_cond();
      host.write_byte({strobe_regs_pkg::BUS_ADDR, 1'b1}, ack);
      chk_bit(ack, 1'b1);
      for (int k = 0; k < n; k++) begin
         host.read_byte(k == n - 1, rbuf[k]);
      end
      host.stop_cond();
   endtask : rd_regs

   task automatic check_outputs();
      logic [7:0] r;
      r = exp_reg[0];
      chk_bit(conv_on, r[6]);
      chk_val(17'(sel), 17'(r[5:4]));
      chk_bit(m_ad, r[5:4] == 2'h0);
      chk_bit(m_fx, r[5:4] == 2'h1);
      chk_bit(m_dr, r[5:4] == 2'h2);
      chk_bit(m_au, r[5:4] == 2'h3);
      chk_val(17'(mv), 17'h0_0E74 + 17'(r[3:0]) * 17'h0_0064);
      chk_val(cur1, exp_cur(exp_reg[1][7:3]));
      chk_val(cur2, exp_cur(exp_reg[2][7:3]));
   endtask : check_outputs

   task automatic read_back(input logic [7:0] ptr, input int n);
      rd_regs(ptr, n);
      for (int k = 0; k < n; k++) begin
         chk_val(17'(rbuf[k]), 17'(ptr + k < 3 ? exp_reg[ptr + k] :
                 8'h00));
      end
   endtask : read_back

   initial begin
      logic [4:0] c1;
      logic [4:0] c2;
      logic [3:0] vc;
      logic       ack;
      err_count   = 0;
      comparisons = 0;
      cycles      = 0;
      seed        = 39989;
      i_nrst      = 1'b0;
      for (int k = 0; k < 3; k++) exp_reg[k] = 8'h00;
      repeat (8) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (10) @(negedge i_clk);
      chk_bit(o_sda_oe, 1'b0);
      chk_bit(o_sda, 1'b0);
      check_outputs();
      read_back(8'h00, 3);
      for (int i = 0; i < 4; i++) begin
         c1 = 5'($random(seed));
         c2 = 5'($random(seed));
         vc = 4'($random(seed));
         case (i)
            0: begin
               c1 = 5'h1E;
               c2 = 5'h1F;
               vc = 4'h0;
            end
            1: begin
               c1 = 5'h1F;
               c2 = 5'h1E;
               vc = 4'hF;
            end
            2: begin
               c1 = 5'h00;
            end
            default: begin
               c2 = 5'h00;
            end
         endcase
         // Reserved bits left at zero
         wbuf[0] = {1'b0, 1'($random(seed)), 2'(i), vc};
         wbuf[1] = {c1, 3'h0};
         wbuf[2] = {c2, 3'h0};
         wr_regs(8'h00, 3);
         check_outputs();
         read_back(8'h00, 3);
         read_back(8'h01, 2);
      end
      wbuf[0] = 8'h5A;
      wr_regs(8'h05, 1);
      read_back(8'h05, 1);
      check_outputs();
      wbuf[0] = 8'h48;
      wr_regs(8'h01, 1);
      check_outputs();
      read_back(8'h00, 3);
      host.start_cond();
      host.write_byte({strobe_regs_pkg::BUS_ADDR ^ 7'h01, 1'b0}, ack);
      chk_bit(ack, 1'b0);
      host.stop_cond();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
